// ===== nmifst_consts.svh
// Register offsets, field positions, reset values and timing counts of the NMI flag block.
`ifndef NMIFST_CONSTS_SVH
`define NMIFST_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define NMIFST_OFF_FLAGS1     12'h000
`define NMIFST_OFF_FLAGS2     12'h004
`define NMIFST_OFF_CLEAR      12'h008
`define NMIFST_OFF_ST_CTRL    12'h00C
`define NMIFST_OFF_ST_STATUS  12'h010
`define NMIFST_OFF_ST_COUNT   12'h014
// ----------------------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------------------
`define NMIFST_BIT_NMIGEN     0
`define NMIFST_BIT_CLKLOSS    1
`define NMIFST_BIT_RAMUNC     2
`define NMIFST_BIT_FLASHUNC   3
`define NMIFST_BIT_ST1ERR     8
`define NMIFST_BIT_ST2ERR     9
`define NMIFST_BIT_VECERR     10
`define NMIFST_BIT_C2WD       12
`define NMIFST_BIT_C2NMIWD    13
`define NMIFST_FLAGS_RESET    16'h0000
`define NMIFST_FLAGS_USED     16'h370F
`define NMIFST_CORE2_MASK     16'h0FFF
// ----------------------------------------------------------------------------
// Self-test status bits and sequencing counts
// ----------------------------------------------------------------------------
`define NMIFST_ST_FULLDONE    0
`define NMIFST_ST_MICRODONE   1
`define NMIFST_ST_NMI         2
`define NMIFST_ST_FAIL        3
`define NMIFST_ST_SIGFAIL     4
`define NMIFST_ST_TOFAIL      5
`define NMIFST_ST_OVERRUN     6
`define NMIFST_COV_LOS        7'd95
`define NMIFST_COV_STUCK      7'd99
`define NMIFST_RUNS_LOS       12'd1700
`define NMIFST_RUNS_STUCK     12'd300
`define NMIFST_ST_RESET       8'h00
`endif

// ===== nmifst_pkg.sv
// Types of the NMI flag and self-test status block.
package nmifst_pkg;
    typedef enum logic [1:0] {
        NMIFST_IDLE  = 2'b00,
        NMIFST_LOS   = 2'b01,
        NMIFST_STUCK = 2'b10,
        NMIFST_DONE  = 2'b11
    } nmifst_phase_t;

    typedef struct packed {
        logic clockLoss;
        logic ramUncorrectable;
        logic flashUncorrectable;
        logic vectorFetchError;
        logic core2WatchdogReset;
        logic core2NmiWatchdogReset;
        logic externalNmi;
    } nmifst_src_t;

    typedef struct packed {
        logic       microDone;
        logic       timeout;
        logic       sigMismatch;
        logic [6:0] coverage;
    } nmifst_run_t;
endpackage

// ===== nmifst_flags.sv
// NMI error flag register with self-test sequencing and status, APB slave.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "nmifst_consts.svh"
// Contract
// - Latch core-1 self-test error at bit 8 on timeout or signature mismatch.
// - Latch core-2 self-test error at bit 9 on timeout or signature mismatch.
// - Flags stay set until a one is written to the clear register or reset.
// - Bit 0 records an issued NMI; no further NMI pulses while it is set.
// - Clock loss latches flag bit 1 as an NMI source.
// - Uncorrectable RAM error from any master latches flag bit 2.
// - Uncorrectable flash error on a CPU access latches flag bit 3.
// - Vector fetch error of the other core latches flag bit 10.
// - Bit 12 set once core-2 watchdog reset fired, zero otherwise.
// - Bit 13 set once core-2 NMI watchdog reset fired, zero otherwise.
// - Core-2 copy of the flag register reads core-2 watchdog bits as zero.
// - Self-test failure NMI goes to both cores.
// - Full run reaches 95% launch-on-shift, then stuck-at up to 99%.
// - Full run not done in expected micro-runs reports overrun failure.
// - Pass shows full-done and micro-done; failure shows failure bit mix.
// - NMI-raised status on external NMI, timeout or logic error.
// - Test-failed on timeout or logic error; signature and timeout marked apart.
// - Controller timeout sets timeout failure and sends NMI to both cores.
module nmifst_flags
    import nmifst_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire nmifst_src_t errSrc,
    input  wire nmifst_run_t stRun,
    output logic             nmiCore1,
    output logic             nmiCore2,
    output logic             stActive
);
    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Error sources arrive from other blocks and pins, so every bit is resynchronised.
    localparam int SRCW = $bits(nmifst_src_t);
    localparam int RUNW = $bits(nmifst_run_t);
    logic [SRCW-1:0] srcMeta_ff;
    logic [SRCW-1:0] srcSync_ff;
    logic [RUNW-1:0] runMeta_ff;
    logic [RUNW-1:0] runSync_ff;
    logic [RUNW-1:0] runPrev_ff;
    nmifst_src_t     src;
    nmifst_run_t     run;
    logic            microPulse;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            srcMeta_ff <= '0;
            srcSync_ff <= '0;
            runMeta_ff <= '0;
            runSync_ff <= '0;
            runPrev_ff <= '0;
        end
        else
        begin
            srcMeta_ff <= errSrc;
            srcSync_ff <= srcMeta_ff;
            runMeta_ff <= stRun;
            runSync_ff <= runMeta_ff;
            runPrev_ff <= runSync_ff;
        end
    end

    assign src = nmifst_src_t'(srcSync_ff);
    assign run = nmifst_run_t'(runSync_ff);
    assign microPulse = run.microDone & ~runPrev_ff[RUNW-1];

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    logic wrStrobe;
    logic selFlags1;
    logic selFlags2;
    logic selClear;
    logic selCtrl;
    logic selStatus;
    logic selCount;
    logic selAny;

    assign wrStrobe  = psel & penable & pwrite;
    assign selFlags1 = paddr == `NMIFST_OFF_FLAGS1;
    assign selFlags2 = paddr == `NMIFST_OFF_FLAGS2;
    assign selClear  = paddr == `NMIFST_OFF_CLEAR;
    assign selCtrl   = paddr == `NMIFST_OFF_ST_CTRL;
    assign selStatus = paddr == `NMIFST_OFF_ST_STATUS;
    assign selCount  = paddr == `NMIFST_OFF_ST_COUNT;
    assign selAny    = selFlags1 | selFlags2 | selClear | selCtrl | selStatus | selCount;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~selAny;

    // ------------------------------------------------------------------------
    // Self-test sequencer
    // ------------------------------------------------------------------------
    nmifst_phase_t phase_ff;
    nmifst_phase_t nxt_phase;
    logic [11:0]   runCount_ff;
    logic [11:0]   nxt_runCount;
    logic [7:0]    stStatus_ff;
    logic [7:0]    nxt_stStatus;
    logic          startReq;
    logic          stopReq;
    logic          runLimit;
    logic          failNow;

    assign startReq = wrStrobe & selCtrl & pwdata[0];
    assign stopReq  = wrStrobe & selCtrl & pwdata[1];
    assign failNow  = microPulse & (run.timeout | run.sigMismatch);
    // The micro-run that is finishing now counts toward the limit.
    assign runLimit = (phase_ff == NMIFST_LOS) ? runCount_ff >= `NMIFST_RUNS_LOS - 12'd1
                                               : runCount_ff >= `NMIFST_RUNS_STUCK - 12'd1;

    always_comb
    begin
        nxt_phase    = phase_ff;
        nxt_runCount = runCount_ff;
        nxt_stStatus = stStatus_ff;
        unique case (phase_ff)
            NMIFST_IDLE, NMIFST_DONE:
            begin
                if (startReq)
                begin
                    nxt_phase    = NMIFST_LOS;
                    nxt_runCount = '0;
                    nxt_stStatus = `NMIFST_ST_RESET;
                end
            end
            NMIFST_LOS, NMIFST_STUCK:
            begin
                if (microPulse)
                begin
                    nxt_runCount = runCount_ff + 12'd1;
                    nxt_stStatus[`NMIFST_ST_MICRODONE] = 1'b1;
                end
                if (failNow)
                begin
                    nxt_stStatus[`NMIFST_ST_NMI]     = 1'b1;
                    nxt_stStatus[`NMIFST_ST_FAIL]    = 1'b1;
                    nxt_stStatus[`NMIFST_ST_SIGFAIL] = run.sigMismatch;
                    nxt_stStatus[`NMIFST_ST_TOFAIL]  = run.timeout;
                    nxt_stStatus[`NMIFST_ST_FULLDONE] = 1'b1;
                    nxt_phase = NMIFST_DONE;
                end
                else if (microPulse && phase_ff == NMIFST_LOS
                         && run.coverage >= `NMIFST_COV_LOS)
                begin
                    nxt_phase    = NMIFST_STUCK;
                    nxt_runCount = '0;
                end
                else if (microPulse && phase_ff == NMIFST_STUCK
                         && run.coverage >= `NMIFST_COV_STUCK)
                begin
                    nxt_stStatus[`NMIFST_ST_FULLDONE] = 1'b1;
                    nxt_phase = NMIFST_DONE;
                end
                else if (microPulse && runLimit)
                begin
                    nxt_stStatus[`NMIFST_ST_OVERRUN]  = 1'b1;
                    nxt_stStatus[`NMIFST_ST_FULLDONE] = 1'b1;
                    nxt_phase = NMIFST_DONE;
                end
                else if (stopReq)
                begin
                    nxt_phase = NMIFST_IDLE;
                end
                if (src.externalNmi)
                begin
                    nxt_stStatus[`NMIFST_ST_NMI] = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------------------
    // Each source only ever sets; clearing is only via the clear register.
    logic [15:0] flags_ff;
    logic [15:0] setVec;
    logic [15:0] clrVec;
    logic [15:0] nxt_flags;
    logic        nmiPulse_ff;
    logic        nxt_nmiPulse;
    logic        anyNmiSource;
    logic        core1Test;

    logic        stRun_core2_sel_ff;
    assign core1Test = ~stRun_core2_sel_ff;

    always_comb
    begin
        setVec = '0;
        setVec[`NMIFST_BIT_ST1ERR]   = failNow & core1Test;
        setVec[`NMIFST_BIT_ST2ERR]   = failNow & ~core1Test;
        setVec[`NMIFST_BIT_CLKLOSS]  = src.clockLoss;
        setVec[`NMIFST_BIT_RAMUNC]   = src.ramUncorrectable;
        setVec[`NMIFST_BIT_FLASHUNC] = src.flashUncorrectable;
        setVec[`NMIFST_BIT_VECERR]   = src.vectorFetchError;
        setVec[`NMIFST_BIT_C2WD]     = src.core2WatchdogReset;
        setVec[`NMIFST_BIT_C2NMIWD]  = src.core2NmiWatchdogReset;
    end

    // A clear in the same cycle as a new event loses, so no event goes missing.
    assign clrVec       = (wrStrobe & selClear) ? pwdata[15:0] : 16'h0000;
    assign anyNmiSource = |(setVec & ~16'h0001) | |(flags_ff & ~16'h0001);
    assign nxt_nmiPulse = anyNmiSource & ~flags_ff[`NMIFST_BIT_NMIGEN];

    always_comb
    begin
        nxt_flags = (flags_ff & ~clrVec) | setVec;
        if (nxt_nmiPulse)
        begin
            nxt_flags[`NMIFST_BIT_NMIGEN] = 1'b1;
        end
        nxt_flags = nxt_flags & `NMIFST_FLAGS_USED;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            flags_ff           <= `NMIFST_FLAGS_RESET;
            nmiPulse_ff        <= 1'b0;
            phase_ff           <= NMIFST_IDLE;
            runCount_ff        <= '0;
            stStatus_ff        <= `NMIFST_ST_RESET;
            stRun_core2_sel_ff <= 1'b0;
        end
        else
        begin
            flags_ff    <= nxt_flags;
            nmiPulse_ff <= nxt_nmiPulse;
            phase_ff    <= nxt_phase;
            runCount_ff <= nxt_runCount;
            stStatus_ff <= nxt_stStatus;
            if (startReq)
            begin
                stRun_core2_sel_ff <= pwdata[2];
            end
        end
    end

    // One NMI pulse reaches both cores, which covers self-test failures too.
    assign nmiCore1 = nmiPulse_ff;
    assign nmiCore2 = nmiPulse_ff;
    assign stActive = (phase_ff == NMIFST_LOS) | (phase_ff == NMIFST_STUCK);

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (selFlags1)
        begin
            nxt_prdata[15:0] = flags_ff;
        end
        if (selFlags2)
        begin
            nxt_prdata[15:0] = flags_ff & `NMIFST_CORE2_MASK;
        end
        if (selCtrl)
        begin
            nxt_prdata[3:0] = {stActive, stRun_core2_sel_ff, phase_ff};
        end
        if (selStatus)
        begin
            nxt_prdata[7:0] = stStatus_ff;
        end
        if (selCount)
        begin
            nxt_prdata[11:0] = runCount_ff;
        end
    end

    // Read data is registered during setup so it is stable across the access cycle.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (psel & ~penable & ~pwrite)
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
endmodule // nmifst_flags

// ===== nmifst_chk.sv
// Checker that watches the NMI flag block at its ports.
`timescale 1ns/100ps
module nmifst_chk
    import nmifst_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire nmifst_src_t errSrc,
    input wire nmifst_run_t stRun,
    input wire logic        nmiCore1,
    input wire logic        nmiCore2,
    input wire logic        stActive
);
    // ------------------------------------------------------------------
    // Mirror of the NMI-generated flag, so a repeated pulse can be seen.
    // ------------------------------------------------------------------
    logic nmiHeld_ff;
    logic nxt_nmiHeld;
    wire  clrNmi  = psel && penable && pwrite && paddr == 12'h008 && pwdata[0];
    wire  rdSetup = psel && !penable && !pwrite;
    assign nxt_nmiHeld = clrNmi ? 1'b0 : (nmiCore1 ? 1'b1 : nmiHeld_ff);
    always_ff @(posedge mclk)
    begin
        nmiHeld_ff <= rst ? 1'b0 : nxt_nmiHeld;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_nmi_both: assert property (nmiCore1 == nmiCore2)
        else $error("NMI outputs differ");
    chk_nmi_pulse: assert property (nmiCore1 |=> !nmiCore1)
        else $error("NMI pulse longer than one cycle");
    chk_nmi_blocked: assert property (nmiCore1 |-> !nmiHeld_ff)
        else $error("NMI repeated while flag set");
    chk_resv_zero: assert property (rdSetup && paddr == 12'h000 |=>
        (prdata & 32'hFFFF_C8F0) == 32'h0000_0000) else $error("Reserved flag bits set");
    chk_core2_mask: assert property (rdSetup && paddr == 12'h004 |=>
        prdata[13:12] == 2'b00) else $error("Core 2 view shows watchdog bits");
    chk_reset_clear: assert property ($fell(rst) |->
        prdata == 32'h0000_0000 && !nmiCore1 && !stActive) else $error("Reset state wrong");
    chk_src_nmi: assert property ($rose(|errSrc[6:1]) && !nmiHeld_ff |->
        ##[1:5] nmiCore1) else $error("Error source raised no NMI");
    chk_st_nmi: assert property ($rose(stRun.microDone) && stActive && !nmiHeld_ff &&
        (stRun.timeout || stRun.sigMismatch) |-> ##[1:6] nmiCore2) else $error("No self-test NMI");
endmodule // nmifst_chk
bind nmifst_flags nmifst_chk nmifst_chk_inst (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .errSrc(errSrc), .stRun(stRun),
    .nmiCore1(nmiCore1), .nmiCore2(nmiCore2), .stActive(stActive));

// ===== nmifst_partner.sv
// Model of the self-test engine side that reports one micro-run per kick.
`timescale 1ns/100ps
module nmifst_partner
    import nmifst_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        kick,
    input  wire nmifst_run_t runCmd,
    output nmifst_run_t      stRun,
    output logic             busy
);
    logic [3:0]  step_ff;
    nmifst_run_t stRun_ff;
    assign stRun = stRun_ff;
    assign busy  = step_ff != 4'h0;
    // Results are held long after the done edge, because the block samples them late.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            step_ff  <= 4'h0;
            stRun_ff <= '0;
        end
        else if (kick && !busy)
        begin
            step_ff  <= 4'h1;
            stRun_ff <= runCmd;
        end
        else if (busy)
        begin
            step_ff            <= step_ff + 4'h1;
            stRun_ff.microDone <= step_ff >= 4'h2 && step_ff <= 4'h5;
        end
    end
endmodule // nmifst_partner

// ===== tb_nmifst_flags.sv
// Testbench of the NMI flag block over APB with a self-test engine model.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_nmifst_flags
    import nmifst_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        kick = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdVal, rdExp;
    logic        pready, pslverr, nmiCore1, nmiCore2, stActive, busy, errVal;
    nmifst_src_t errSrc = '0;
    nmifst_run_t runCmd = '0;
    nmifst_run_t stRun;
    int          fail_count = 0;
    int          check_count = 0;
    int          nmiCount = 0;
    int          nmi2Count = 0;
    int          n0;
    int          n2;
    int          fb [7] = '{0, 13, 12, 10, 3, 2, 1};
    always #10 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (nmiCore1 === 1'b1) nmiCount++;
        if (nmiCore2 === 1'b1) nmi2Count++;
    end
    nmifst_flags nmifst_flags_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .errSrc(errSrc), .stRun(stRun), .nmiCore1(nmiCore1),
        .nmiCore2(nmiCore2), .stActive(stActive));
    nmifst_partner nmifst_partner_inst (.mclk(mclk), .rst(rst), .kick(kick),
        .runCmd(runCmd), .stRun(stRun), .busy(busy));
    // ------------------------------------------------------------------
    // Bus and stimulus tasks.
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apbXfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        tick(1);
        penable <= 1'b1;
        tick(1);
        while (pready !== 1'b1) tick(1);
        rdVal = prdata;
        errVal = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    task automatic apbRd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apbXfer(1'b0, a, 32'h0000_0000);
        `CHK(rdVal & m, e)
    endtask
    task automatic srcPulse(input int i);
        errSrc[i] <= 1'b1;
        tick(4);
        errSrc <= '0;
        tick(4);
    endtask
    task automatic microRun(input logic [6:0] cov, input logic to, input logic sig);
        runCmd <= '{1'b0, to, sig, cov};
        kick   <= 1'b1;
        tick(1);
        kick   <= 1'b0;
        tick(1);
        while (busy === 1'b1) tick(1);
    endtask
    task automatic doReset();
        rst <= 1'b1;
        tick(6);
        rst <= 1'b0;
        tick(1);
    endtask
    task final_report;
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(50000);
        fail_count++;
        final_report();
    end
    initial
    begin
        doReset();
        for (int a = 0; a < 6; a++) apbRd(12'(a * 4), 32'hFFFF_FFFF, 32'h0000_0000);
        apbRd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000);
        `CHK(errVal, 1'b1)
        for (int i = 1; i < 7; i++)
        begin
            n0 = nmiCount;
            srcPulse(i);
            rdExp = 32'h0000_0001 | (32'h0000_0001 << fb[i]);
            apbRd(12'h000, 32'hFFFF_FFFF, rdExp);
            apbRd(12'h004, 32'hFFFF_FFFF, rdExp & 32'hFFFF_CFFF);
            `CHK(nmiCount - n0, 1)
            apbXfer(1'b1, 12'h000, 32'h0000_FFFF);
            apbRd(12'h000, 32'hFFFF_FFFF, rdExp);
            apbXfer(1'b1, 12'h008, rdExp);
            apbRd(12'h000, 32'hFFFF_FFFF, 32'h0000_0000);
        end
        n0 = nmiCount;
        srcPulse(6);
        srcPulse(5);
        `CHK(nmiCount - n0, 1)
        apbXfer(1'b1, 12'h008, 32'h0000_0001);
        tick(2);
        `CHK(nmiCount - n0, 2)
        apbRd(12'h000, 32'hFFFF_FFFF, 32'h0000_0007);
        `CHK(errVal, 1'b0)
        apbXfer(1'b1, 12'h008, 32'h0000_0307);
        apbXfer(1'b1, 12'h00C, 32'h0000_0001);
        `CHK(stActive, 1'b1)
        microRun(7'd99, 1'b0, 1'b0);
        apbRd(12'h010, 32'h0000_007F, 32'h0000_0002);
        `CHK(stActive, 1'b1)
        microRun(7'd99, 1'b0, 1'b0);
        apbRd(12'h010, 32'h0000_007F, 32'h0000_0003);
        `CHK(stActive, 1'b0)
        apbRd(12'h000, 32'hFFFF_FFFF, 32'h0000_0000);
        for (int f = 0; f < 2; f++)
        begin
            doReset();
            apbXfer(1'b1, 12'h00C, f ? 32'h0000_0001 : 32'h0000_0005);
            n0 = nmiCount;
            n2 = nmi2Count;
            microRun(7'd40, f == 0, f == 1);
            apbRd(12'h010, 32'h0000_007F, f ? 32'h0000_001F : 32'h0000_002F);
            apbRd(12'h000, 32'hFFFF_FFFF, f ? 32'h0000_0101 : 32'h0000_0201);
            `CHK(nmiCount - n0, 1)
            `CHK(nmi2Count - n2, 1)
        end
        doReset();
        apbXfer(1'b1, 12'h00C, 32'h0000_0001);
        srcPulse(0);
        apbRd(12'h010, 32'h0000_0004, 32'h0000_0004);
        apbXfer(1'b1, 12'h00C, 32'h0000_0002);
        `CHK(stActive, 1'b0)
        doReset();
        apbXfer(1'b1, 12'h00C, 32'h0000_0001);
        repeat (1700) microRun(7'd10, 1'b0, 1'b0);
        apbRd(12'h010, 32'h0000_007F, 32'h0000_0043);
        apbRd(12'h014, 32'h0000_0FFF, 32'h0000_06A4);
        final_report();
    end
endmodule // tb_nmifst_flags
